// ### rtl/olnm_pkg.sv
// Behaviour
// - Compare absolute samples against 24-bit limits
// - Overvoltage sets status bit 18, phase bit
// - Mask bit 18 routes overvoltage to interrupt
// - Writing bit 18 clears overvoltage flags
// - Mask bit 17 routes overcurrent to interrupt
// - Overcurrent sets status bit 17, phase bit
// - Writing bit 17 clears overcurrent flags
// - Limit at filter maximum never trips
// - Limit of zero trips on every sample
// - Limits read as words, upper byte zero
// - Sum three currents into 28-bit signed register
// - Sum updates each sample, sets ready flag
// - Config bit 14 selects sum rms source
// - Delta connection forces phase B current zero
// - Mismatch flag when magnitude difference exceeds threshold
// - Mask bit 20 routes mismatch to interrupt
// - Writing bit 20 clears mismatch flag
// - Signed threshold resets zero, nonpositive always trips
// - Sum reads with upper four bits zero
// - Threshold reads sign-extended to 28, zero-padded
`default_nettype none
package olnm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [17:0] OLNM_IDX_MISMATCH_THRESHOLD = 18'h0_4398;
  localparam logic [17:0] OLNM_IDX_NEUTRAL_RMS = 18'h0_43c9;
  localparam logic [17:0] OLNM_IDX_PHASE_CURRENT_SUM = 18'h0_43ca;
  localparam logic [17:0] OLNM_IDX_ZEROTH_STATUS = 18'h0_e502;
  localparam logic [17:0] OLNM_IDX_FIRST_STATUS = 18'h0_e503;
  localparam logic [17:0] OLNM_IDX_CURRENT_LIMIT = 18'h0_e507;
  localparam logic [17:0] OLNM_IDX_VOLTAGE_LIMIT = 18'h0_e508;
  localparam logic [17:0] OLNM_IDX_PHASE_A_CURRENT = 18'h0_e50c;
  localparam logic [17:0] OLNM_IDX_PHASE_B_CURRENT = 18'h0_e50d;
  localparam logic [17:0] OLNM_IDX_PHASE_C_CURRENT = 18'h0_e50e;
  localparam logic [17:0] OLNM_IDX_NEUTRAL_CURRENT = 18'h0_e50f;
  localparam logic [17:0] OLNM_IDX_FIRST_MASK = 18'h0_e52b;
  localparam logic [17:0] OLNM_IDX_PER_PHASE_STATUS = 18'h0_e600;
  localparam logic [17:0] OLNM_IDX_CONFIG = 18'h0_e618;
  localparam logic [17:0] OLNM_IDX_ACCUMULATION_MODE = 18'h0_e701;

  // Field positions
  localparam int OLNM_BIT_SAMPLE_READY = 17;
  localparam int OLNM_BIT_OVERCURRENT = 17;
  localparam int OLNM_BIT_OVERVOLTAGE = 18;
  localparam int OLNM_BIT_MISMATCH = 20;
  localparam int OLNM_POS_OV_PHASE = 9;
  localparam int OLNM_POS_OI_PHASE = 3;
  localparam int OLNM_BIT_RMS_SOURCE = 14;
  localparam int OLNM_POS_CONNECTION = 4;
  localparam logic [1:0] OLNM_CONNECTION_DELTA = 2'h1;

  // Reset values
  localparam logic [23:0] OLNM_LIMIT_MAX = 24'h51_2d40;
  localparam logic [23:0] OLNM_RST_LIMIT = 24'h51_2d40;
  localparam logic [23:0] OLNM_RST_THRESHOLD = 24'h00_0000;
  localparam logic [31:0] OLNM_RST_WORD = 32'h0000_0000;

  // Sample timing
  localparam int OLNM_CLK_PERIOD_PS = 5000;
  localparam int OLNM_SAMPLE_PERIOD_NS = 125000;
  localparam int OLNM_SAMPLE_CYCLES = (OLNM_SAMPLE_PERIOD_NS * 1000) / OLNM_CLK_PERIOD_PS;

  function automatic logic [23:0] olnm_abs24(input logic [23:0] v);
    return v[23] ? 24'(-v) : v;
  endfunction

  function automatic logic [27:0] olnm_abs28(input logic [27:0] v);
    return v[27] ? 28'(-v) : v;
  endfunction
endpackage
`default_nettype wire

// ### rtl/olnm_cmp.sv
`default_nettype none
module olnm_cmp
  import olnm_pkg::*;
(
  input wire logic [23:0] sample,
  input wire logic [23:0] limit,
  output logic exceeds
);
  logic [23:0] magnitude;
  logic limit_zero;
  logic limit_live;

  assign magnitude = olnm_abs24(sample);
  assign limit_zero = (limit == 24'h00_0000);
  // Limits at or above the filter ceiling are treated as disabled
  assign limit_live = (limit < OLNM_LIMIT_MAX);
  assign exceeds = limit_zero | (limit_live & (magnitude > limit));
endmodule
`default_nettype wire

// ### rtl/olnm_top.sv
// Our own choice: the APB slave port.
`default_nettype none
module olnm_top
  import olnm_pkg::*;
#(
  parameter int SAMPLE_CYCLES = OLNM_SAMPLE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [23:0] voltage_sample_a,
  input wire logic [23:0] voltage_sample_b,
  input wire logic [23:0] voltage_sample_c,
  input wire logic [23:0] current_sample_a,
  input wire logic [23:0] current_sample_b,
  input wire logic [23:0] current_sample_c,
  input wire logic [23:0] neutral_current_sample,
  input wire logic [23:0] neutral_current_rms,
  input wire logic [23:0] current_sum_rms,
  output logic [27:0] current_sum_out,
  output logic sample_strobe,
  output logic interrupt_line_n
);
  ////////////////////////////////////////////////////////////////////////////
  // Sample rate divider
  logic [15:0] div_count;
  logic div_wrap;
  assign div_wrap = (div_count == 16'(SAMPLE_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= 16'h0000;
    end else begin
      div_count <= div_wrap ? 16'h0000 : 16'(div_count + 16'h0001);
    end
  end
  assign sample_strobe = div_wrap;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [17:0] idx;
  logic setup_phase;
  logic wr_access;
  assign idx = paddr[19:2];
  assign setup_phase = psel & ~penable;
  assign pready = 1'b1;
  assign wr_access = psel & penable & pwrite;

  logic hit_thr, hit_nrms, hit_sum, hit_st0, hit_st1, hit_ilim, hit_vlim;
  logic hit_ia, hit_ib, hit_ic, hit_in, hit_mask, hit_phst, hit_cfg, hit_acc;
  logic hit_any;
  assign hit_thr = (idx == OLNM_IDX_MISMATCH_THRESHOLD);
  assign hit_nrms = (idx == OLNM_IDX_NEUTRAL_RMS);
  assign hit_sum = (idx == OLNM_IDX_PHASE_CURRENT_SUM);
  assign hit_st0 = (idx == OLNM_IDX_ZEROTH_STATUS);
  assign hit_st1 = (idx == OLNM_IDX_FIRST_STATUS);
  assign hit_ilim = (idx == OLNM_IDX_CURRENT_LIMIT);
  assign hit_vlim = (idx == OLNM_IDX_VOLTAGE_LIMIT);
  assign hit_ia = (idx == OLNM_IDX_PHASE_A_CURRENT);
  assign hit_ib = (idx == OLNM_IDX_PHASE_B_CURRENT);
  assign hit_ic = (idx == OLNM_IDX_PHASE_C_CURRENT);
  assign hit_in = (idx == OLNM_IDX_NEUTRAL_CURRENT);
  assign hit_mask = (idx == OLNM_IDX_FIRST_MASK);
  assign hit_phst = (idx == OLNM_IDX_PER_PHASE_STATUS);
  assign hit_cfg = (idx == OLNM_IDX_CONFIG);
  assign hit_acc = (idx == OLNM_IDX_ACCUMULATION_MODE);
  assign hit_any = hit_thr | hit_nrms | hit_sum | hit_st0 | hit_st1 | hit_ilim | hit_vlim |
                   hit_ia | hit_ib | hit_ic | hit_in | hit_mask | hit_phst | hit_cfg | hit_acc;

  // Read-only registers ignore writes silently; only unmapped words answer with an error
  logic wr_thr, wr_st0, wr_st1, wr_ilim, wr_vlim, wr_mask, wr_cfg, wr_acc;
  assign wr_thr = wr_access & hit_thr;
  assign wr_st0 = wr_access & hit_st0;
  assign wr_st1 = wr_access & hit_st1;
  assign wr_ilim = wr_access & hit_ilim;
  assign wr_vlim = wr_access & hit_vlim;
  assign wr_mask = wr_access & hit_mask;
  assign wr_cfg = wr_access & hit_cfg;
  assign wr_acc = wr_access & hit_acc;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [23:0] mismatch_threshold;
  logic [23:0] current_limit;
  logic [23:0] voltage_limit;
  logic [31:0] first_interrupt_mask;
  logic [31:0] config_word;
  logic [31:0] accumulation_mode_register;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mismatch_threshold <= OLNM_RST_THRESHOLD;
      current_limit <= OLNM_RST_LIMIT;
      voltage_limit <= OLNM_RST_LIMIT;
      first_interrupt_mask <= OLNM_RST_WORD;
      config_word <= OLNM_RST_WORD;
      accumulation_mode_register <= OLNM_RST_WORD;
    end else begin
      if (wr_thr) mismatch_threshold <= pwdata[23:0];
      if (wr_ilim) current_limit <= pwdata[23:0];
      if (wr_vlim) voltage_limit <= pwdata[23:0];
      if (wr_mask) first_interrupt_mask <= pwdata;
      if (wr_cfg) config_word <= pwdata;
      if (wr_acc) accumulation_mode_register <= pwdata;
    end
  end

  logic rms_source_sum;
  logic delta_mode;
  assign rms_source_sum = config_word[OLNM_BIT_RMS_SOURCE];
  assign delta_mode = (accumulation_mode_register[OLNM_POS_CONNECTION +: 2] ==
                       OLNM_CONNECTION_DELTA);

  ////////////////////////////////////////////////////////////////////////////
  // Over-limit comparators, voltages in lanes 0..2, currents in 3..5
  logic [23:0] phase_b_current;
  assign phase_b_current = delta_mode ? 24'h00_0000 : current_sample_b;

  logic [23:0] cmp_sample [6];
  logic [23:0] cmp_limit [6];
  logic [5:0] cmp_exceeds;
  assign cmp_sample[0] = voltage_sample_a;
  assign cmp_sample[1] = voltage_sample_b;
  assign cmp_sample[2] = voltage_sample_c;
  assign cmp_sample[3] = current_sample_a;
  assign cmp_sample[4] = phase_b_current;
  assign cmp_sample[5] = current_sample_c;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_cmp
      assign cmp_limit[gi] = (gi < 3) ? voltage_limit : current_limit;
      olnm_cmp u_cmp (
        .sample(cmp_sample[gi]),
        .limit(cmp_limit[gi]),
        .exceeds(cmp_exceeds[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Current sum and mismatch
  logic [27:0] next_sum;
  assign next_sum = 28'(signed'(current_sample_a)) + 28'(signed'(phase_b_current)) +
                    28'(signed'(current_sample_c));

  logic [27:0] phase_current_sum;
  logic [23:0] held_a, held_b, held_c, held_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_current_sum <= 28'h000_0000;
      held_a <= 24'h00_0000;
      held_b <= 24'h00_0000;
      held_c <= 24'h00_0000;
      held_n <= 24'h00_0000;
    end else if (sample_strobe) begin
      phase_current_sum <= next_sum;
      held_a <= current_sample_a;
      held_b <= phase_b_current;
      held_c <= current_sample_c;
      held_n <= neutral_current_sample;
    end
  end
  assign current_sum_out = phase_current_sum;

  // Compared on the fresh sum so the flag and the stored sum describe the same sample
  logic [27:0] sum_mag;
  logic [27:0] neutral_mag;
  logic [27:0] diff_mag;
  logic [27:0] thr_mag;
  logic thr_nonpositive;
  logic mismatch_now;
  assign sum_mag = olnm_abs28(next_sum);
  assign neutral_mag = {4'h0, olnm_abs24(neutral_current_sample)};
  assign diff_mag = olnm_abs28(28'(sum_mag - neutral_mag));
  assign thr_mag = {4'h0, olnm_abs24(mismatch_threshold)};
  assign thr_nonpositive = mismatch_threshold[23] | (mismatch_threshold == 24'h00_0000);
  assign mismatch_now = thr_nonpositive | (diff_mag > thr_mag);

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a set in the same cycle as a clear wins
  logic overvoltage_flag, overcurrent_flag, mismatch_flag, sample_ready_flag;
  logic [2:0] overvoltage_phase_bits, overcurrent_phase_bits;
  logic clr_ov, clr_oi, clr_mm, clr_rdy;
  logic [2:0] set_ov, set_oi;
  assign clr_ov = wr_st1 & pwdata[OLNM_BIT_OVERVOLTAGE];
  assign clr_oi = wr_st1 & pwdata[OLNM_BIT_OVERCURRENT];
  assign clr_mm = wr_st1 & pwdata[OLNM_BIT_MISMATCH];
  assign clr_rdy = wr_st0 & pwdata[OLNM_BIT_SAMPLE_READY];
  assign set_ov = sample_strobe ? cmp_exceeds[2:0] : 3'h0;
  assign set_oi = sample_strobe ? cmp_exceeds[5:3] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overvoltage_flag <= 1'b0;
      overcurrent_flag <= 1'b0;
      mismatch_flag <= 1'b0;
      sample_ready_flag <= 1'b0;
      overvoltage_phase_bits <= 3'h0;
      overcurrent_phase_bits <= 3'h0;
    end else begin
      overvoltage_flag <= (overvoltage_flag & ~clr_ov) | (|set_ov);
      overvoltage_phase_bits <= (overvoltage_phase_bits & {3{~clr_ov}}) | set_ov;
      overcurrent_flag <= (overcurrent_flag & ~clr_oi) | (|set_oi);
      overcurrent_phase_bits <= (overcurrent_phase_bits & {3{~clr_oi}}) | set_oi;
      mismatch_flag <= (mismatch_flag & ~clr_mm) | (sample_strobe & mismatch_now);
      sample_ready_flag <= (sample_ready_flag & ~clr_rdy) | sample_strobe;
    end
  end

  logic [31:0] first_status;
  logic [31:0] zeroth_status;
  logic [15:0] per_phase_status;
  always_comb begin
    first_status = 32'h0000_0000;
    first_status[OLNM_BIT_OVERVOLTAGE] = overvoltage_flag;
    first_status[OLNM_BIT_OVERCURRENT] = overcurrent_flag;
    first_status[OLNM_BIT_MISMATCH] = mismatch_flag;
    zeroth_status = 32'h0000_0000;
    zeroth_status[OLNM_BIT_SAMPLE_READY] = sample_ready_flag;
    per_phase_status = 16'h0000;
    per_phase_status[OLNM_POS_OV_PHASE +: 3] = overvoltage_phase_bits;
    per_phase_status[OLNM_POS_OI_PHASE +: 3] = overcurrent_phase_bits;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt line
  logic irq_pending;
  assign irq_pending = |(first_status & first_interrupt_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_line_n <= 1'b1;
    end else begin
      interrupt_line_n <= ~irq_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, captured in the setup cycle
  logic [23:0] neutral_rms;
  logic [31:0] rd_word;
  assign neutral_rms = rms_source_sum ? current_sum_rms : neutral_current_rms;
  assign rd_word =
    hit_thr ? {4'h0, {4{mismatch_threshold[23]}}, mismatch_threshold} :
    hit_nrms ? {8'h00, neutral_rms} :
    hit_sum ? {4'h0, phase_current_sum} :
    hit_st0 ? zeroth_status :
    hit_st1 ? first_status :
    hit_ilim ? {8'h00, current_limit} :
    hit_vlim ? {8'h00, voltage_limit} :
    hit_ia ? {8'h00, held_a} :
    hit_ib ? {8'h00, held_b} :
    hit_ic ? {8'h00, held_c} :
    hit_in ? {8'h00, held_n} :
    hit_mask ? first_interrupt_mask :
    hit_phst ? {16'h0000, per_phase_status} :
    hit_cfg ? config_word :
    hit_acc ? accumulation_mode_register :
    32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr <= ~hit_any;
    end
  end
endmodule
`default_nettype wire

// ### verification/olnm_top_asserts.sv
`default_nettype none
module olnm_top_asserts
  import olnm_pkg::*;
#(
  parameter int SAMPLE_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [23:0] current_sample_a,
  input wire logic [23:0] current_sample_b,
  input wire logic [23:0] current_sample_c,
  input wire logic [27:0] current_sum_out,
  input wire logic sample_strobe,
  input wire logic interrupt_line_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cnt;
  wire logic rsetup = psel && !penable && !pwrite;
  wire logic wacc = psel && penable && pwrite;
  wire logic [17:0] idx = paddr[19:2];
  wire logic [27:0] s_ac = {{4{current_sample_a[23]}}, current_sample_a}
    + {{4{current_sample_c[23]}}, current_sample_c};
  wire logic [27:0] s_abc = s_ac + {{4{current_sample_b[23]}}, current_sample_b};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // Mirror of the sample divider, so the strobe spacing is checked exactly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 32'h0000_0000;
    else if (cnt == 32'(SAMPLE_CYCLES - 1)) cnt <= 32'h0000_0000;
    else cnt <= cnt + 32'h0000_0001;
  end
  property p_strobe;
    sample_strobe == (cnt == 32'(SAMPLE_CYCLES - 1));
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe spacing wrong");
  // Delta mode may drop phase B, so either sum is accepted
  property p_sum_val;
    sample_strobe |=> (current_sum_out == $past(s_abc) || current_sum_out == $past(s_ac));
  endproperty
  a_sum_val: assert property (p_sum_val) else $error("sum value wrong");
  property p_sum_hold;
    $changed(current_sum_out) |-> $past(sample_strobe) || $past(sample_strobe, 2);
  endproperty
  a_sum_hold: assert property (p_sum_hold) else $error("sum moved off strobe");
  property p_irq_fall;
    $fell(interrupt_line_n) |-> $past(sample_strobe, 2) || $past(wacc, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell uncaused");
  property p_irq_rise;
    $rose(interrupt_line_n) |-> $past(wacc, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose uncaused");
  property p_lim_fmt;
    rsetup && (idx == OLNM_IDX_CURRENT_LIMIT || idx == OLNM_IDX_VOLTAGE_LIMIT)
      |=> prdata[31:24] == 8'h00;
  endproperty
  a_lim_fmt: assert property (p_lim_fmt) else $error("limit word format");
  property p_sum_fmt;
    rsetup && idx == OLNM_IDX_PHASE_CURRENT_SUM |=> prdata[31:28] == 4'h0;
  endproperty
  a_sum_fmt: assert property (p_sum_fmt) else $error("sum word format");
  property p_thr_fmt;
    rsetup && idx == OLNM_IDX_MISMATCH_THRESHOLD |=> prdata[31:24] == {4'h0, {4{prdata[23]}}};
  endproperty
  a_thr_fmt: assert property (p_thr_fmt) else $error("threshold word format");
  c_strobe: cover property (sample_strobe);
  c_fall: cover property ($fell(interrupt_line_n));
  c_rise: cover property ($rose(interrupt_line_n));
endmodule
`default_nettype wire

// ### verification/olnm_host_model.sv
`default_nettype none
module olnm_host_model
  import olnm_pkg::*;
(
  input wire logic pclk,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [19:0] paddr,
  output var logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 20'h0_0000;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [17:0] idx, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Released lines wander so nobody can lean on a stale value
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
  // Status first, then phases, and only then the clear
  task automatic service(input int b, output logic [31:0] st, output logic [31:0] ph);
    logic [31:0] q;
    logic e;
    xfer(1'h0, OLNM_IDX_FIRST_STATUS, 32'h0000_0000, st, e);
    xfer(1'h0, OLNM_IDX_PER_PHASE_STATUS, 32'h0000_0000, ph, e);
    xfer(1'h1, OLNM_IDX_FIRST_STATUS, 32'h0000_0001 << b, q, e);
  endtask
  task automatic init(input logic [23:0] thr);
    logic [31:0] q;
    logic e;
    xfer(1'h1, OLNM_IDX_MISMATCH_THRESHOLD, {8'h00, thr}, q, e);
  endtask
endmodule
`default_nettype wire

// ### verification/test_olnm_top.sv
`default_nettype none
module test_olnm_top;
  import olnm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stb, irq_n;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] va, vb, vc, ia, ib, ic, inn, rms_n, rms_s;
  logic [27:0] sum;
  int n_fail, n_checks, cyc;
  olnm_top #(.SAMPLE_CYCLES(20)) u_olnm_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .voltage_sample_a(va), .voltage_sample_b(vb),
    .voltage_sample_c(vc), .current_sample_a(ia), .current_sample_b(ib),
    .current_sample_c(ic), .neutral_current_sample(inn), .neutral_current_rms(rms_n),
    .current_sum_rms(rms_s), .current_sum_out(sum), .sample_strobe(stb),
    .interrupt_line_n(irq_n));
  olnm_host_model u_olnm_host_model (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  always #2.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // The line is registered one cycle behind the flags, so let two edges pass
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, exp}, {31'h0, irq_n});
  endtask
  task automatic rd(input string nm, input logic [17:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    u_olnm_host_model.xfer(1'h0, idx, 32'h0000_0000, q, e);
    chk(nm, exp, q);
  endtask
  task automatic wr(input logic [17:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    u_olnm_host_model.xfer(1'h1, idx, d, q, e);
  endtask
  // Past the evaluation edge and the registered interrupt edge
  task automatic tick();
    @(posedge stb);
    repeat (3) @(posedge pclk);
  endtask
  // Generous ceiling: the sequence needs under 2000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q, st, ph;
    logic e;
    {pclk, presetn, va, vb, vc, ia, ib, ic, inn} = '0;
    rms_n = 24'h00_1111;
    rms_s = 24'h00_2222;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    rd("thr", OLNM_IDX_MISMATCH_THRESHOLD, 32'h0000_0000);
    rd("ilim", OLNM_IDX_CURRENT_LIMIT, {8'h00, OLNM_LIMIT_MAX});
    u_olnm_host_model.xfer(1'h0, 18'h0_0001, 32'h0000_0000, q, e);
    chk("err", 32'h0000_0001, {31'h0, e});
    wr(OLNM_IDX_FIRST_MASK, 32'h0010_0000);
    tick();
    irq_is(1'b0);
    rd("st1", OLNM_IDX_FIRST_STATUS, 32'h0010_0000);
    rd("st0", OLNM_IDX_ZEROTH_STATUS, 32'h0002_0000);
    u_olnm_host_model.init(24'h00_0100);
    wr(OLNM_IDX_FIRST_STATUS, 32'h0010_0000);
    irq_is(1'b1);
    wr(OLNM_IDX_MISMATCH_THRESHOLD, 32'h0fff_ff00);
    rd("thr", OLNM_IDX_MISMATCH_THRESHOLD, 32'h0fff_ff00);
    tick();
    rd("st1", OLNM_IDX_FIRST_STATUS, 32'h0010_0000);
    u_olnm_host_model.init(24'h00_0100);
    ia <= 24'hf0_0000;
    ib <= 24'hf0_0000;
    ic <= 24'hf0_0000;
    inn <= 24'h30_0000;
    wr(OLNM_IDX_FIRST_STATUS, 32'h0010_0000);
    tick();
    rd("sum", OLNM_IDX_PHASE_CURRENT_SUM, 32'h0fd0_0000);
    rd("st1", OLNM_IDX_FIRST_STATUS, 32'h0000_0000);
    inn <= 24'h30_0101;
    tick();
    rd("st1", OLNM_IDX_FIRST_STATUS, 32'h0010_0000);
    inn <= 24'h30_0100;
    wr(OLNM_IDX_FIRST_STATUS, 32'h0010_0000);
    tick();
    rd("st1", OLNM_IDX_FIRST_STATUS, 32'h0000_0000);
    irq_is(1'b1);
    wr(OLNM_IDX_FIRST_MASK, 32'h0000_0000);
    wr(OLNM_IDX_ACCUMULATION_MODE, 32'h0000_0010);
    tick();
    rd("sum", OLNM_IDX_PHASE_CURRENT_SUM, 32'h0fe0_0000);
    rd("ib", OLNM_IDX_PHASE_B_CURRENT, 32'h0000_0000);
    wr(OLNM_IDX_ACCUMULATION_MODE, 32'h0000_0000);
    rd("nrms", OLNM_IDX_NEUTRAL_RMS, 32'h0000_1111);
    wr(OLNM_IDX_CONFIG, 32'h0000_4000);
    rd("nrms", OLNM_IDX_NEUTRAL_RMS, 32'h0000_2222);
    inn <= 24'h0f_ffff;
    ic <= 24'h10_0001;
    wr(OLNM_IDX_FIRST_MASK, 32'h0002_0000);
    wr(OLNM_IDX_CURRENT_LIMIT, 32'h0010_0000);
    tick();
    wr(OLNM_IDX_FIRST_STATUS, 32'h0010_0000);
    tick();
    irq_is(1'b0);
    ic <= 24'hf0_0000;
    inn <= 24'h30_0000;
    u_olnm_host_model.service(17, st, ph);
    chk("st1", 32'h0002_0000, st);
    chk("phs", 32'h0000_0020, ph);
    rd("phs", OLNM_IDX_PER_PHASE_STATUS, 32'h0000_0000);
    irq_is(1'b1);
    wr(OLNM_IDX_FIRST_MASK, 32'h0004_0000);
    wr(OLNM_IDX_VOLTAGE_LIMIT, 32'h0000_0000);
    va <= 24'h00_0005;
    tick();
    irq_is(1'b0);
    u_olnm_host_model.service(18, st, ph);
    chk("ov", 32'h0004_0000, st & 32'h0004_0000);
    chk("ovph", 32'h0000_0200, ph & 32'h0000_0200);
    tick();
    irq_is(1'b0);
    // Far above the ceiling, so only the disable logic keeps the flag clear
    va <= 24'h7f_ffff;
    wr(OLNM_IDX_VOLTAGE_LIMIT, {8'h00, OLNM_LIMIT_MAX});
    tick();
    wr(OLNM_IDX_FIRST_STATUS, 32'h0004_0000);
    tick();
    rd("st1", OLNM_IDX_FIRST_STATUS, 32'h0000_0000);
    rd("phs", OLNM_IDX_PER_PHASE_STATUS, 32'h0000_0000);
    irq_is(1'b1);
    tally_and_finish();
  end
endmodule
bind olnm_top olnm_top_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_olnm_top_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .current_sample_a(current_sample_a),
  .current_sample_b(current_sample_b), .current_sample_c(current_sample_c),
  .current_sum_out(current_sum_out), .sample_strobe(sample_strobe),
  .interrupt_line_n(interrupt_line_n));
`default_nettype wire
